/* File: hdl/sam_address_mapper.sv */
// sdram address mapper: cpu byte address to bank, row, column and lane
`timescale 1ns/100ps
//
// How it works
// R1: 32-bit bus: two low bits select byte
// R2: 16-bit bus: bit zero selects byte
// R3: bank high bit to pin one, low to zero
// R4: 2K rows: 11-bit row above column, bank above
// R5: 4K rows: 12-bit row, bank directly above
// R6: 8K rows: 13-bit row, bank directly above
// R7: split chosen from held configuration register
// R8: address bits above bank are ignored
module sam_address_mapper
    import sam_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration load
    input wire logic cfgLoad,
    input wire sam_cfg_t cfgIn,
    output sam_cfg_t cfgReg,
    // request from the system bus master
    input wire logic reqValid,
    input wire logic [SAM_ADDR_W-1:0] reqAddr,
    output logic reqReady,
    // mapped address to the command sequencer
    output logic outValid,
    input wire logic outReady,
    output sam_map_t outMap,
    output logic bankPinOne,
    output logic bankPinZero
);

    ////////////////////////////////////////////////////////////////////////
    // field geometry from the held configuration

    wire take = reqValid && reqReady;
    wire [4:0] byteBits;
    wire [4:0] colBits;
    wire [4:0] rowBits;
    wire [4:0] colShift;
    wire [4:0] rowShift;
    wire [4:0] bankShift;
    wire [SAM_COL_MAX_W-1:0] colField;
    wire [SAM_ROW_MAX_W-1:0] rowField;
    wire [SAM_BANK_W-1:0] bankField;
    wire [SAM_BYTE_W-1:0] byteField;
    sam_map_t next_map;

    // lane field width follows the data bus width
    assign byteBits = cfgReg.bus16 ? SAM_BYTE_BITS_16 // R2
                                   : SAM_BYTE_BITS_32; // R1
    assign colBits = SAM_COL_BITS_BASE + {3'h0, cfgReg.colSel}; // R7
    assign rowBits = (cfgReg.rowSel == SAM_ROWS_4K) ? SAM_ROW_BITS_4K // R5
                   : (cfgReg.rowSel == SAM_ROWS_8K) ? SAM_ROW_BITS_8K // R6
                   : SAM_ROW_BITS_2K; // R4
    assign colShift = byteBits; // R1 R2
    assign rowShift = colShift + colBits; // R4 R5 R6
    assign bankShift = rowShift + rowBits; // R4 R5 R6

    // lane select: bit zero only on a 16-bit bus
    assign byteField = cfgReg.bus16 ? {1'b0, reqAddr[0]} // R2
                                    : reqAddr[1:0]; // R1

    ////////////////////////////////////////////////////////////////////////
    // field extraction; each slice masks everything above its length

    sam_field_slice #(.ADDR_W(SAM_ADDR_W), .MAXW(SAM_COL_MAX_W)) colSlice (
        .addr(reqAddr),
        .shift(colShift),
        .width(colBits),
        .field(colField)
    );

    sam_field_slice #(.ADDR_W(SAM_ADDR_W), .MAXW(SAM_ROW_MAX_W)) rowSlice (
        .addr(reqAddr),
        .shift(rowShift),
        .width(rowBits),
        .field(rowField)
    );

    // bits above the bank field never reach any output
    sam_field_slice #(.ADDR_W(SAM_ADDR_W), .MAXW(SAM_BANK_W)) bankSlice (
        .addr(reqAddr),
        .shift(bankShift),
        .width(SAM_BANK_BITS),
        .field(bankField) // R8
    );

    assign next_map = '{bank: bankField, row: rowField, col: colField,
                        byteSel: byteField};

    ////////////////////////////////////////////////////////////////////////
    // handshake: one register stage, stalls when the sequencer stalls

    assign reqReady = !outValid || outReady;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgReg <= SAM_CFG_RESET;
        end else if (cfgLoad) begin
            cfgReg <= cfgIn; // R7
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outValid <= 1'b0;
        end else if (reqReady) begin
            outValid <= reqValid;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outMap <= SAM_MAP_RESET;
            bankPinOne <= 1'b0;
            bankPinZero <= 1'b0;
        end else if (take) begin
            outMap <= next_map;
            bankPinOne <= bankField[1]; // R3
            bankPinZero <= bankField[0]; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    byte_lane_32_a: assert property ( // R1
        take && !cfgReg.bus16 |=> outValid &&
            outMap.byteSel == $past(reqAddr[1:0]) &&
            outMap.col[0] == $past(reqAddr[2]))
        else $error("32-bit lane or column start wrong");

    byte_lane_16_a: assert property ( // R2
        take && cfgReg.bus16 |=> outMap.byteSel == {1'b0, $past(reqAddr[0])}
            && outMap.col[0] == $past(reqAddr[1]))
        else $error("16-bit lane or column start wrong");

    bank_pin_map_a: assert property ( // R3
        outValid |-> bankPinOne == outMap.bank[1] &&
            bankPinZero == outMap.bank[0])
        else $error("bank pins do not follow bank field");

    rows_2k_split_a: assert property ( // R4
        take && !cfgReg.bus16 && cfgReg.rowSel == SAM_ROWS_2K &&
            cfgReg.colSel == SAM_COLS_256
        |=> outMap.col == {3'h0, $past(reqAddr[9:2])} &&
            outMap.row == {2'h0, $past(reqAddr[20:10])} &&
            outMap.bank == $past(reqAddr[22:21]))
        else $error("2K row split wrong");

    rows_4k_split_a: assert property ( // R5
        take && cfgReg.bus16 && cfgReg.rowSel == SAM_ROWS_4K &&
            cfgReg.colSel == SAM_COLS_512
        |=> outMap.col == {2'h0, $past(reqAddr[9:1])} &&
            outMap.row == {1'h0, $past(reqAddr[21:10])} &&
            outMap.bank == $past(reqAddr[23:22]))
        else $error("4K row split wrong");

    rows_8k_split_a: assert property ( // R6
        take && !cfgReg.bus16 && cfgReg.rowSel == SAM_ROWS_8K &&
            cfgReg.colSel == SAM_COLS_2048
        |=> outMap.col == $past(reqAddr[12:2]) &&
            outMap.row == $past(reqAddr[25:13]) &&
            outMap.bank == $past(reqAddr[27:26]))
        else $error("8K row split wrong");

    cfg_load_a: assert property ( // R7
        cfgLoad |=> cfgReg == $past(cfgIn))
        else $error("configuration register not loaded");

    cfg_hold_a: assert property ( // R7
        !cfgLoad |=> $stable(cfgReg))
        else $error("configuration register changed without a load");

    rows_4k_32bit_a: assert property ( // R5
        take && !cfgReg.bus16 && cfgReg.rowSel == SAM_ROWS_4K &&
            cfgReg.colSel == SAM_COLS_1024
        |=> outMap.col == {1'h0, $past(reqAddr[11:2])} &&
            outMap.row == {1'h0, $past(reqAddr[23:12])} &&
            outMap.bank == $past(reqAddr[25:24]))
        else $error("4K row split on a 32-bit bus wrong");

    rows_8k_16bit_a: assert property ( // R6
        take && cfgReg.bus16 && cfgReg.rowSel == SAM_ROWS_8K &&
            cfgReg.colSel == SAM_COLS_256
        |=> outMap.col == {3'h0, $past(reqAddr[8:1])} &&
            outMap.row == $past(reqAddr[21:9]) &&
            outMap.bank == $past(reqAddr[23:22]))
        else $error("8K row split on a 16-bit bus wrong");

    reserved_rows_a: assert property ( // R4
        take && cfgReg.bus16 && cfgReg.rowSel == 2'h3 &&
            cfgReg.colSel == SAM_COLS_2048
        |=> outMap.col == $past(reqAddr[11:1]) &&
            outMap.row == {2'h0, $past(reqAddr[22:12])} &&
            outMap.bank == $past(reqAddr[24:23]))
        else $error("reserved row code not mapped as 2K rows");

    req_refused_a: assert property (
        outValid && !outReady |-> !reqReady)
        else $error("request accepted while the sequencer stalls");

    out_drop_a: assert property (
        outValid && outReady && !reqValid |=> !outValid)
        else $error("mapped address not released after acceptance");

    out_answer_a: assert property (
        take |=> outValid)
        else $error("taken request gave no mapped address");

    field_bound_a: assert property ( // R8
        take && cfgReg.colSel == SAM_COLS_1024 &&
            cfgReg.rowSel == SAM_ROWS_2K
        |=> outMap.col[10] == 1'b0 && outMap.row[12:11] == 2'h0)
        else $error("field carries bits beyond its length");

    out_hold_a: assert property (
        outValid && !outReady |=> outValid && $stable(outMap))
        else $error("mapped address changed while stalled");

endmodule : sam_address_mapper

/* File: hdl/sam_field_slice.sv */
// extracts one variable-position, variable-length field of an address
`timescale 1ns/100ps
module sam_field_slice #(
    parameter int ADDR_W = 28,
    parameter int MAXW = 13
) (
    // address and field placement
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [4:0] shift,
    input wire logic [4:0] width,
    // extracted field, zero above its length
    output logic [MAXW-1:0] field
);
    wire [ADDR_W-1:0] shifted = addr >> shift;
    wire [MAXW-1:0] mask = ~({MAXW{1'b1}} << width);

    assign field = shifted[MAXW-1:0] & mask;

endmodule : sam_field_slice

/* File: hdl/sam_pkg.sv */
// package of constants and carriers for the sdram address mapper
package sam_pkg;

    localparam int SAM_ADDR_W = 28;
    localparam int SAM_BANK_W = 2;
    localparam int SAM_ROW_MAX_W = 13;
    localparam int SAM_COL_MAX_W = 11;
    localparam int SAM_BYTE_W = 2;
    localparam int SAM_SHIFT_W = 5;

    // field lengths in address bits
    localparam logic [4:0] SAM_BYTE_BITS_32 = 5'h2;
    localparam logic [4:0] SAM_BYTE_BITS_16 = 5'h1;
    localparam logic [4:0] SAM_COL_BITS_BASE = 5'h8;
    localparam logic [4:0] SAM_ROW_BITS_2K = 5'hb;
    localparam logic [4:0] SAM_ROW_BITS_4K = 5'hc;
    localparam logic [4:0] SAM_ROW_BITS_8K = 5'hd;
    localparam logic [4:0] SAM_BANK_BITS = 5'h2;

    // row count selection codes
    localparam logic [1:0] SAM_ROWS_2K = 2'h0;
    localparam logic [1:0] SAM_ROWS_4K = 2'h1;
    localparam logic [1:0] SAM_ROWS_8K = 2'h2;

    // column count selection codes: 256, 512, 1024, 2048
    localparam logic [1:0] SAM_COLS_256 = 2'h0;
    localparam logic [1:0] SAM_COLS_512 = 2'h1;
    localparam logic [1:0] SAM_COLS_1024 = 2'h2;
    localparam logic [1:0] SAM_COLS_2048 = 2'h3;

    typedef struct packed {
        logic bus16;
        logic [1:0] rowSel;
        logic [1:0] colSel;
    } sam_cfg_t;

    localparam sam_cfg_t SAM_CFG_RESET = '{bus16: 1'b0,
        rowSel: 2'h0, colSel: 2'h0};

    typedef struct packed {
        logic [SAM_BANK_W-1:0] bank;
        logic [SAM_ROW_MAX_W-1:0] row;
        logic [SAM_COL_MAX_W-1:0] col;
        logic [SAM_BYTE_W-1:0] byteSel;
    } sam_map_t;

    localparam sam_map_t SAM_MAP_RESET = '0;

endpackage : sam_pkg

/* File: verif/sam_address_mapper_test.sv */
// self-checking bench for the sdram address mapper
`timescale 1ns/100ps
module sam_address_mapper_test;
    import sam_pkg::*;
    logic clk, rst, cfgLoad, reqValid, reqReady, outValid, outReady;
    logic stall, bankPinOne, bankPinZero;
    sam_cfg_t cfgIn, cfgReg, c;
    logic [SAM_ADDR_W-1:0] reqAddr;
    sam_map_t outMap;
    int fails, totalChecks, cycles;
    // one test row: configuration, address and the map that they give
    typedef struct packed {
        sam_cfg_t cfg;
        logic [27:0] addr;
        sam_map_t want;
    } sam_row_t;
    sam_row_t rows [52];

    sam_address_mapper dut (.clk(clk), .rst(rst), .cfgLoad(cfgLoad),
        .cfgIn(cfgIn), .cfgReg(cfgReg), .reqValid(reqValid),
        .reqAddr(reqAddr), .reqReady(reqReady), .outValid(outValid),
        .outReady(outReady), .outMap(outMap), .bankPinOne(bankPinOne),
        .bankPinZero(bankPinZero));
    sam_seq_model seq (.clk(clk), .rst(rst), .stall(stall),
        .outReady(outReady));

    function automatic sam_map_t expect_map(sam_cfg_t k, logic [27:0] x);
        sam_map_t r;
        int b, cw, rw;
        b = k.bus16 ? 1 : 2;
        cw = 8 + k.colSel;
        rw = (k.rowSel == SAM_ROWS_4K) ? 12
           : (k.rowSel == SAM_ROWS_8K) ? 13 : 11;
        r.byteSel = k.bus16 ? {1'b0, x[0]} : x[1:0];
        r.col = SAM_COL_MAX_W'((x >> b) & ((28'h1 << cw) - 28'h1));
        r.row = SAM_ROW_MAX_W'((x >> (b + cw)) & ((28'h1 << rw) - 28'h1));
        r.bank = SAM_BANK_W'(x >> (b + cw + rw));
        return r;
    endfunction : expect_map

    task automatic check(logic [27:0] seen, logic [27:0] want);
        totalChecks++;
        if (seen !== want) begin
            fails++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic load(sam_cfg_t k);
        @(posedge clk);
        cfgLoad <= 1'b1;
        cfgIn <= k;
        @(posedge clk);
        cfgLoad <= 1'b0;
    endtask : load

    // holds the request through the rising edge after reqReady is seen high at a falling edge
    task automatic send(logic [27:0] x);
        @(posedge clk);
        reqValid <= 1'b1;
        reqAddr <= x;
        @(negedge clk);
        while (reqReady !== 1'b1) @(negedge clk);
        @(posedge clk);
        reqValid <= 1'b0;
    endtask : send

    task automatic look(sam_map_t w);
        check({27'h0, outValid}, 28'h1);
        check(outMap, w);
        check({26'h0, bankPinOne, bankPinZero}, {26'h0, w.bank});
    endtask : look

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, cfgLoad, cfgIn, reqValid, reqAddr, stall} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({23'h0, cfgReg}, {23'h0, SAM_CFG_RESET});
        check({26'h0, outValid, reqReady}, 28'h1);
        check(outMap, SAM_MAP_RESET);
        // every width, row and column split, two addresses each
        for (int i = 0; i < 48; i++) begin
            rows[i].cfg = '{bus16: 1'(i / 24), rowSel: 2'((i / 2) % 3),
                colSel: 2'((i / 6) % 4)};
            rows[i].addr = i[0] ? 28'hfffffff : 28'ha5c3e69 + 28'(i);
            rows[i].want = expect_map(rows[i].cfg, rows[i].addr);
        end
        // worked by hand: 2K, 4K, reserved row code, 8K with bit 27 aliased
        rows[48] = '{cfg: '{bus16: 1'b0, rowSel: SAM_ROWS_2K,
            colSel: SAM_COLS_256}, addr: 28'h0600c0d,
            want: '{bank: 2'h3, row: 13'h003, col: 11'h003, byteSel: 2'h1}};
        rows[49] = '{cfg: '{bus16: 1'b1, rowSel: SAM_ROWS_4K,
            colSel: SAM_COLS_512}, addr: 28'h0c3fffe,
            want: '{bank: 2'h3, row: 13'h0ff, col: 11'h1ff, byteSel: 2'h0}};
        rows[50] = '{cfg: '{bus16: 1'b1, rowSel: 2'h3,
            colSel: SAM_COLS_2048}, addr: 28'h1800801,
            want: '{bank: 2'h3, row: 13'h000, col: 11'h400, byteSel: 2'h1}};
        rows[51] = '{cfg: '{bus16: 1'b0, rowSel: SAM_ROWS_8K,
            colSel: SAM_COLS_1024}, addr: 28'ha000004,
            want: '{bank: 2'h1, row: 13'h000, col: 11'h001, byteSel: 2'h0}};
        foreach (rows[i]) begin
            load(rows[i].cfg);
            @(negedge clk);
            check({23'h0, cfgReg}, {23'h0, rows[i].cfg});
            send(rows[i].addr);
            @(negedge clk);
            look(rows[i].want);
        end
        // stalled sequencer: second request waits, held map survives a
        // configuration change
        stall <= 1'b1;
        c = '{bus16: 1'b1, rowSel: SAM_ROWS_4K, colSel: SAM_COLS_512};
        load(c);
        send(28'h0c3fffe);
        fork
            send(28'h6d2b457);
            begin
                load('{bus16: 1'b0, rowSel: SAM_ROWS_8K, colSel: 2'h3});
                repeat (2) @(negedge clk);
                look(expect_map(c, 28'h0c3fffe));
                check({27'h0, reqReady}, 28'h0);
                @(posedge clk);
                stall <= 1'b0;
            end
        join
        @(negedge clk);
        look(expect_map('{bus16: 1'b0, rowSel: SAM_ROWS_8K, colSel: 2'h3},
            28'h6d2b457));
        // reset in mid-run while a map is held
        stall <= 1'b1;
        send(28'h1234567);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        check({27'h0, outValid}, 28'h0);
        check({23'h0, cfgReg}, {23'h0, SAM_CFG_RESET});
        check(outMap, SAM_MAP_RESET);
        check({26'h0, bankPinOne, bankPinZero}, 28'h0);
        @(posedge clk);
        rst <= 1'b0;
        stall <= 1'b0;
        // first request straight after release, mapped with the reset split
        send(28'h0000404);
        @(negedge clk);
        look('{bank: 2'h0, row: 13'h001, col: 11'h001, byteSel: 2'h0});
        summarize();
    end
endmodule : sam_address_mapper_test

/* File: verif/sam_seq_model.sv */
// command sequencer stand-in that takes mapped addresses
`timescale 1ns/100ps
module sam_seq_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stall request from the bench
    input wire logic stall,
    // accept side of the mapped address handshake
    output logic outReady
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outReady <= 1'b0;
        end else begin
            outReady <= !stall;
        end
    end
endmodule : sam_seq_model
